// [shared/prs_pkg.sv]
// constants for the power-on reset sequencer
// assumes a single 100 MHz clock driving the whole block
package prs_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  // input clock period in ns
  localparam int unsigned CLK_PERIOD_NS    = 10;
  // fixed sequence counts, in clock cycles
  localparam int unsigned CONFIG_CYCLES    = 1024;
  localparam int unsigned PLL_LOCK_CYCLES  = 800;
  localparam int unsigned DLL_LOCK_CYCLES  = 3073;
  localparam int unsigned HARD_HOLD_CYCLES = 512;
  localparam int unsigned SOFT_LAG_CYCLES  = 3;
  localparam int unsigned CNT_W            = 13;
  // wishbone register byte offsets
  localparam logic [3:0]  ADDR_CTRL        = 4'h0;
  localparam logic [3:0]  ADDR_STATUS      = 4'h4;
  localparam logic [3:0]  ADDR_CFGWORD     = 4'h8;
  localparam logic [3:0]  ADDR_PINS        = 4'hc;
  // ctrl register bits
  localparam int unsigned CTRL_CFG_BYTE_LSB = 0;
  localparam int unsigned CTRL_CFG_WR_BIT   = 8;
  localparam int unsigned CTRL_CLR_EXT_BIT  = 9;
  // configuration word fields
  localparam int unsigned CW_DLL_BYPASS_BIT = 0;
  localparam int unsigned CW_CLOCK_MODE_HIGH_FIELD_LSB    = 4;
  localparam int unsigned CW_CLOCK_MODE_HIGH_FIELD_W      = 4;
  localparam logic [31:0] CFG_WORD_RESET    = 32'h0000_0000;
  // boot source codes
  localparam logic [1:0]  BOOT_EXT_MEM      = 2'h0;
  localparam logic [1:0]  BOOT_HOST         = 2'h1;
  typedef enum {
    ST_HOLD, ST_CONFIG, ST_HOST_WAIT, ST_PLL, ST_DLL, ST_HARD, ST_SOFT,
    ST_RUN
  } prs_state_type;
endpackage

// [logic/prs_sync2.sv]
// two-stage synchroniser for one level
// assumes the input may be asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module prs_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      level_o
);
  logic meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      meta_q  <= level_i;
      level_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [logic/prs_counter.sv]
// loadable down counter with a done flag
// assumes load and run never coincide with reset
`timescale 1ns/1ns
`default_nettype none
module prs_counter (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       load_i,
  input  wire logic [prs_pkg::CNT_W-1:0]  value_i,
  output logic                            done_o
);
  logic [prs_pkg::CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // plain compare: the load is decided from done, so no path runs back
  assign done_o = cnt_q == '0;
endmodule
`default_nettype wire

// [logic/prs_sequencer.sv]
// power-on reset and reset configuration sequencer
// assumes all pins synchronous to clk_i except power_on_reset_n_i
`timescale 1ns/1ns
`default_nettype none
module prs_sequencer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        power_on_reset_n_i,
  input  wire logic        config_role_strap_i,
  input  wire logic        host_port_enable_strap_i,
  input  wire logic [1:0]  boot_source_strap_i,
  input  wire logic        debug_request_strap_i,
  input  wire logic [2:0]  clock_mode_pins_i,
  input  wire logic        hard_reset_n_i,
  output logic             hard_reset_n_o,
  output logic             hard_reset_n_oe_n_o,
  input  wire logic        soft_reset_n_i,
  output logic             soft_reset_n_o,
  output logic             soft_reset_n_oe_n_o,
  output logic             internal_por_o,
  output logic             clocks_enable_o,
  output logic [6:0]       pll_ratio_o,
  output logic             host_port_enabled_o,
  output logic             bus_wide_32_o,
  output logic             config_slave_o,
  output logic             boot_from_host_o,
  output logic             boot_reserved_o,
  output logic             debug_mode_o,
  output logic             dll_bypass_o,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o
);
  ////////////////////////////////////////////////////////////////////////
  prs_pkg::prs_state_type     state_q;
  logic                       por_sync;
  logic                       por_prev_q;
  logic                       por_rise;
  logic                       cnt_load;
  logic [prs_pkg::CNT_W-1:0]  cnt_value;
  logic                       cnt_done;
  logic [31:0]                cfg_word_q;
  logic [1:0]                 byte_idx_q;
  logic                       cfg_done_q;
  logic                       host_mode_q;
  logic                       ext_hard_q;
  logic                       ext_soft_q;
  logic                       wb_hit;
  logic                       cfg_wr;
  logic                       clr_ext;

  prs_sync2 u_por_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (power_on_reset_n_i),
    .level_o (por_sync)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_prev_q <= 1'b0;
    end else begin
      por_prev_q <= por_sync;
    end
  end

  assign por_rise = por_sync && !por_prev_q;

  prs_counter u_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (cnt_load),
    .value_i (cnt_value),
    .done_o  (cnt_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // straps at release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_mode_q         <= 1'b0;
      config_slave_o      <= 1'b0;
      boot_from_host_o    <= 1'b0;
      boot_reserved_o     <= 1'b0;
      host_port_enabled_o <= 1'b0;
      bus_wide_32_o       <= 1'b0;
    end else if (por_rise) begin
      host_mode_q         <= host_port_enable_strap_i;
      host_port_enabled_o <= host_port_enable_strap_i;
      bus_wide_32_o       <= host_port_enable_strap_i;
      config_slave_o      <= config_role_strap_i;
      boot_from_host_o    <= boot_source_strap_i == prs_pkg::BOOT_HOST;
      boot_reserved_o     <= boot_source_strap_i != prs_pkg::BOOT_HOST &&
                             boot_source_strap_i != prs_pkg::BOOT_EXT_MEM;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence control
  // counts load one less: the cycle at zero belongs to the state too
  always_comb begin
    cnt_load  = 1'b0;
    cnt_value = '0;
    case (state_q)
      prs_pkg::ST_HOLD: begin
        cnt_load  = por_rise;
        cnt_value = prs_pkg::CNT_W'(prs_pkg::CONFIG_CYCLES - 1);
      end
      prs_pkg::ST_CONFIG, prs_pkg::ST_HOST_WAIT: begin
        cnt_load  = cnt_done && (!host_mode_q || cfg_done_q);
        cnt_value = prs_pkg::CNT_W'(prs_pkg::PLL_LOCK_CYCLES - 1);
      end
      prs_pkg::ST_PLL: begin
        cnt_load  = cnt_done;
        cnt_value = cfg_word_q[prs_pkg::CW_DLL_BYPASS_BIT] ?
                    prs_pkg::CNT_W'(prs_pkg::HARD_HOLD_CYCLES - 1) :
                    prs_pkg::CNT_W'(prs_pkg::DLL_LOCK_CYCLES - 1);
      end
      prs_pkg::ST_DLL: begin
        cnt_load  = cnt_done;
        cnt_value = prs_pkg::CNT_W'(prs_pkg::HARD_HOLD_CYCLES - 1);
      end
      prs_pkg::ST_HARD: begin
        cnt_load  = cnt_done;
        cnt_value = prs_pkg::CNT_W'(prs_pkg::SOFT_LAG_CYCLES - 1);
      end
      default: begin
        cnt_load  = 1'b0;
        cnt_value = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !por_sync) begin
      state_q <= prs_pkg::ST_HOLD;
    end else begin
      case (state_q)
        prs_pkg::ST_HOLD:
          if (por_rise) state_q <= prs_pkg::ST_CONFIG;
        prs_pkg::ST_CONFIG:
          if (cnt_done) state_q <= host_mode_q && !cfg_done_q ?
                                   prs_pkg::ST_HOST_WAIT : prs_pkg::ST_PLL;
        prs_pkg::ST_HOST_WAIT:
          if (cfg_done_q) state_q <= prs_pkg::ST_PLL;
        prs_pkg::ST_PLL:
          if (cnt_done) state_q <= cfg_word_q[prs_pkg::CW_DLL_BYPASS_BIT] ?
                                   prs_pkg::ST_HARD : prs_pkg::ST_DLL;
        prs_pkg::ST_DLL:
          if (cnt_done) state_q <= prs_pkg::ST_HARD;
        prs_pkg::ST_HARD:
          if (cnt_done) state_q <= prs_pkg::ST_SOFT;
        prs_pkg::ST_SOFT:
          if (cnt_done) state_q <= prs_pkg::ST_RUN;
        default: state_q <= state_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock mode and debug captures
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_ratio_o  <= '0;
      debug_mode_o <= 1'b0;
    end else begin
      if ((state_q == prs_pkg::ST_CONFIG ||
           state_q == prs_pkg::ST_HOST_WAIT) && cnt_load) begin
        pll_ratio_o <= {cfg_word_q[prs_pkg::CW_CLOCK_MODE_HIGH_FIELD_LSB +:
                                   prs_pkg::CW_CLOCK_MODE_HIGH_FIELD_W],
                        clock_mode_pins_i};
      end
      if (state_q == prs_pkg::ST_PLL && cnt_done) begin
        debug_mode_o <= debug_request_strap_i;
      end
    end
  end

  always_comb begin
    internal_por_o  = state_q == prs_pkg::ST_HOLD ||
                      state_q == prs_pkg::ST_CONFIG ||
                      state_q == prs_pkg::ST_HOST_WAIT;
    clocks_enable_o = !internal_por_o && state_q != prs_pkg::ST_PLL;
    dll_bypass_o    = cfg_word_q[prs_pkg::CW_DLL_BYPASS_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // resets held through sequence
  always_comb begin
    hard_reset_n_o      = 1'b0;
    soft_reset_n_o      = 1'b0;
    hard_reset_n_oe_n_o = state_q == prs_pkg::ST_SOFT ||
                          state_q == prs_pkg::ST_RUN;
    soft_reset_n_oe_n_o = state_q == prs_pkg::ST_RUN;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_hard_q <= 1'b0;
      ext_soft_q <= 1'b0;
    end else if (state_q == prs_pkg::ST_RUN) begin
      if (!hard_reset_n_i) begin
        ext_hard_q <= 1'b1;
      end else if (clr_ext) begin
        ext_hard_q <= 1'b0;
      end
      if (!soft_reset_n_i || !hard_reset_n_i) begin
        ext_soft_q <= 1'b1;
      end else if (clr_ext) begin
        ext_soft_q <= 1'b0;
      end
    end else if (clr_ext) begin
      ext_hard_q <= 1'b0;
      ext_soft_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave, one registered ack per request, a cycle after the request is seen
  assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge where the master samples ack high
  assign cfg_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                   wb_adr_i == prs_pkg::ADDR_CTRL &&
                   wb_sel_i[1] && wb_dat_i[prs_pkg::CTRL_CFG_WR_BIT];
  assign clr_ext = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                   wb_adr_i == prs_pkg::ADDR_CTRL &&
                   wb_sel_i[1] && wb_dat_i[prs_pkg::CTRL_CLR_EXT_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i || !por_sync) begin
      cfg_word_q <= prs_pkg::CFG_WORD_RESET;
      byte_idx_q <= 2'h0;
      cfg_done_q <= 1'b0;
    end else if (cfg_wr && host_mode_q && !cfg_done_q &&
                 state_q != prs_pkg::ST_HOLD && wb_sel_i[0]) begin
      cfg_word_q[byte_idx_q*8 +: 8] <= wb_dat_i[7:0];
      byte_idx_q <= byte_idx_q + 2'h1;
      if (byte_idx_q == 2'h3) begin
        cfg_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          prs_pkg::ADDR_STATUS:
            wb_dat_o <= {20'h0, ext_soft_q, ext_hard_q, debug_mode_o,
                         boot_reserved_o, boot_from_host_o, config_slave_o,
                         host_mode_q, cfg_done_q, byte_idx_q, internal_por_o,
                         clocks_enable_o};
          prs_pkg::ADDR_CFGWORD: wb_dat_o <= cfg_word_q;
          prs_pkg::ADDR_PINS:    wb_dat_o <= {25'h0, pll_ratio_o};
          default:               wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [dv/prs_board_model.sv]
// board side: power-on reset source, role strap pull-up, reset pin pull-ups
// assumes restart_i and ext_hard_i are driven on clk_i edges
`timescale 1ns/1ns
`default_nettype none
module prs_board_model (
  input  wire logic clk_i,
  input  wire logic restart_i,
  input  wire logic host_mode_i,
  input  wire logic role_i,
  input  wire logic hard_oe_n_i,
  input  wire logic soft_oe_n_i,
  input  wire logic ext_hard_i,
  output logic      por_n_o,
  output logic      role_o,
  output logic      hard_pin_o,
  output logic      soft_pin_o
);
  logic [4:0] low_q = 5'h0;
  always_ff @(posedge clk_i) begin
    if (restart_i) low_q <= 5'h0;
    else if (low_q != 5'h10) low_q <= low_q + 5'h1;
  end
  assign por_n_o = !restart_i && low_q == 5'h10;
  assign role_o = host_mode_i | role_i;
  // open-drain pins idle high through pull-ups
  assign hard_pin_o = !ext_hard_i && hard_oe_n_i;
  assign soft_pin_o = soft_oe_n_i;
endmodule
`default_nettype wire

// [dv/prs_sequencer_assertions.sv]
// timing checks on the reset sequencer ports
// assumes bind from the bench top, single clock domain
`timescale 1ns/1ns
`default_nettype none
module prs_sequencer_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_n_i,
  input wire logic hard_reset_n_o,
  input wire logic hard_reset_n_oe_n_o,
  input wire logic soft_reset_n_o,
  input wire logic soft_reset_n_oe_n_o,
  input wire logic internal_por_o,
  input wire logic clocks_enable_o,
  input wire logic host_port_enabled_o,
  input wire logic dll_bypass_o
);
  logic [12:0] cfg_cnt_q;
  logic [12:0] lock_cnt_q;
  // cycles since por release, loose upper bound covers the synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i || !power_on_reset_n_i) cfg_cnt_q <= 13'h0;
    else if (internal_por_o) cfg_cnt_q <= cfg_cnt_q + 13'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || internal_por_o) lock_cnt_q <= 13'h0;
    else if (lock_cnt_q != 13'h1fff) lock_cnt_q <= lock_cnt_q + 13'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  drive_low_a: assert property (
    !hard_reset_n_o && !soft_reset_n_o) else $error("pin not driven low");
  soft_after_hard_a: assert property (
    soft_reset_n_oe_n_o |-> hard_reset_n_oe_n_o) else $error("soft early");
  soft_lag_a: assert property (
    $rose(hard_reset_n_oe_n_o) |-> !soft_reset_n_oe_n_o[*3] ##1
    soft_reset_n_oe_n_o) else $error("soft lag wrong");
  por_restart_a: assert property (
    !power_on_reset_n_i[*5] |-> internal_por_o && !hard_reset_n_oe_n_o
    && !soft_reset_n_oe_n_o) else $error("por did not restart");
  held_in_por_a: assert property (
    internal_por_o |-> !hard_reset_n_oe_n_o && !clocks_enable_o)
    else $error("released during por");
  config_len_a: assert property (
    $fell(internal_por_o) && !host_port_enabled_o |-> cfg_cnt_q >= 13'h400
    && cfg_cnt_q <= 13'h410) else $error("config length wrong");
  pll_len_a: assert property (
    $rose(clocks_enable_o) |-> lock_cnt_q >= 13'h320 && lock_cnt_q <= 13'h328)
    else $error("pll wait wrong");
  release_len_a: assert property (
    $rose(hard_reset_n_oe_n_o) |-> (dll_bypass_o ? (lock_cnt_q >= 13'h520 &&
    lock_cnt_q <= 13'h530) : (lock_cnt_q >= 13'h1121 && lock_cnt_q <= 13'h1131)))
    else $error("hard release time wrong");
endmodule
`default_nettype wire

// [dv/prs_sequencer_tb_top.sv]
// bench for the reset sequencer: straps, board model and wishbone host
// assumes checker and board model compiled first
`timescale 1ns/1ns
`default_nettype none
module prs_sequencer_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        restart, host_port_enable_strap, role, dbg, ext_hard, we, cyc, ack;
  logic        por_n, role_pin, hard_pin, soft_pin, hard_oe_n, soft_oe_n;
  logic        int_por, clk_en, host_en, wide, slave, boot_host, boot_rsv;
  logic        debug, bypass;
  logic [1:0]  boot;
  logic [2:0]  mode;
  logic [6:0]  ratio;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, q;
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #5 clk_i = ~clk_i;
  prs_board_model board (.clk_i(clk_i), .restart_i(restart), .host_mode_i(host_port_enable_strap),
    .role_i(role), .hard_oe_n_i(hard_oe_n), .soft_oe_n_i(soft_oe_n),
    .ext_hard_i(ext_hard), .por_n_o(por_n), .role_o(role_pin),
    .hard_pin_o(hard_pin), .soft_pin_o(soft_pin));
  prs_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .power_on_reset_n_i(por_n),
    .config_role_strap_i(role_pin), .host_port_enable_strap_i(host_port_enable_strap),
    .boot_source_strap_i(boot), .debug_request_strap_i(dbg),
    .clock_mode_pins_i(mode), .hard_reset_n_i(hard_pin), .hard_reset_n_o(),
    .hard_reset_n_oe_n_o(hard_oe_n), .soft_reset_n_i(soft_pin),
    .soft_reset_n_o(), .soft_reset_n_oe_n_o(soft_oe_n),
    .internal_por_o(int_por), .clocks_enable_o(clk_en), .pll_ratio_o(ratio),
    .host_port_enabled_o(host_en), .bus_wide_32_o(wide),
    .config_slave_o(slave), .boot_from_host_o(boot_host),
    .boot_reserved_o(boot_rsv), .debug_mode_o(debug), .dll_bypass_o(bypass),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack));
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host side runs on the bench clock, never on device clocks
  // classic cycle, held until ack is sampled; only the timeout ends a wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic power_up(input logic h, input logic r, input logic [1:0] b);
    @(posedge clk_i);
    restart <= 1'b1;
    host_port_enable_strap <= h;
    role <= r;
    boot <= b;
    repeat (3) @(posedge clk_i);
    restart <= 1'b0;
    repeat (28) @(posedge clk_i);
  endtask
  task automatic run_to_release();
    while (soft_oe_n !== 1'b1) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    {restart, host_port_enable_strap, role, dbg, ext_hard, we, cyc, boot, adr, wdat} = '0;
    sel = 4'hf;
    restart = 1'b1;
    mode = 3'h6;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // each new power-up aborts the previous sequence mid-config
    for (int i = 0; i < 4; i++) begin
      power_up(1'b0, i[0], i[1:0]);
      chk(boot_host, i == 1);
      chk(boot_rsv, i > 1);
      chk(host_en | wide, 0);
      role <= !role;
      repeat (2) @(posedge clk_i);
      chk(slave, i[0]);
    end
    power_up(1'b0, 1'b0, 2'h0);
    wb(1'b1, 4'h0, 32'h0000_0111, 4'hf);
    wb(1'b0, 4'h8, 32'h0, 4'hf);
    chk(q, 32'h0);
    ext_hard <= 1'b1;
    repeat (3) @(posedge clk_i);
    ext_hard <= 1'b0;
    run_to_release();
    chk({hard_oe_n, soft_oe_n, clk_en, int_por}, 4'he);
    chk({bypass, debug, ratio}, {2'h0, 4'h0, 3'h6});
    wb(1'b0, 4'h4, 32'h0, 4'hf);
    chk(q[11:10], 2'h0);
    ext_hard <= 1'b1;
    repeat (3) @(posedge clk_i);
    ext_hard <= 1'b0;
    wb(1'b0, 4'h4, 32'h0, 4'hf);
    chk(q[11:10], 2'h3);
    wb(1'b1, 4'h0, 32'h0000_0200, 4'hf);
    wb(1'b0, 4'h4, 32'h0, 4'hf);
    chk(q[11:10], 2'h0);
    dbg <= 1'b1;
    mode <= 3'h3;
    power_up(1'b1, 1'b0, 2'h1);
    wb(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
    // byte lane 0 not selected: must not count as a word byte
    wb(1'b1, 4'h0, 32'h0000_01ee, 4'he);
    repeat (1100) @(posedge clk_i);
    // fifth byte must be ignored once the word is complete
    for (int j = 0; j < 5; j++) begin
      if (j == 3) chk(int_por, 1);
      wb(1'b1, 4'h0, {23'h0, 1'b1, 8'(8'h11 * (j + 1))}, 4'hf);
    end
    chk(int_por, 0);
    wb(1'b0, 4'h8, 32'h0, 4'hf);
    chk(q, 32'h4433_2211);
    run_to_release();
    chk({host_en, wide, slave, boot_host}, 4'hf);
    chk({bypass, debug, ratio}, {2'h3, 4'h1, 3'h3});
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    chk(q, 32'h0000_000b);
    chk(soft_oe_n, 1);
    report_and_stop();
  end
endmodule
bind prs_sequencer prs_sequencer_checker chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .power_on_reset_n_i(power_on_reset_n_i), .hard_reset_n_o(hard_reset_n_o),
  .hard_reset_n_oe_n_o(hard_reset_n_oe_n_o), .soft_reset_n_o(soft_reset_n_o),
  .soft_reset_n_oe_n_o(soft_reset_n_oe_n_o), .internal_por_o(internal_por_o),
  .clocks_enable_o(clocks_enable_o), .dll_bypass_o(dll_bypass_o),
  .host_port_enabled_o(host_port_enabled_o));
`default_nettype wire
